// [hdl/vrspc_deglitch.sv]
module vrspc_deglitch
   import vrspc_pkg::*;
#(
   parameter int CNT_W = CNT_W_DEF
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             en,
   input  wire logic             din,
   input  wire logic [CNT_W-1:0] limit,
   output logic                  dout
);
   logic             out_reg;
   logic             out_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   wire              differs = (din != out_reg);
   wire              longEnough = (cnt_reg >= limit);

   // a change passes only after standing for more than limit clocks, either edge direction
   assign out_next = (!en || (differs && longEnough)) ? din : out_reg;
   assign cnt_next = (!differs || out_next != out_reg) ? '0 : cnt_reg + 1'b1;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         out_reg <= out_next;
         cnt_reg <= cnt_next;
      end
   end

   assign dout = out_reg;
endmodule

// [hdl/vrspc_pkg.sv]
package vrspc_pkg;
   localparam int CNT_W_DEF      = 24;
   localparam int LADDER_W_DEF   = 15;
   localparam int CFG_W          = 8;
   localparam int CODE_W         = 4;
   localparam int THR_LSB        = 4;
   localparam int BLANK_LSB      = 0;
   localparam int BLANK_SHIFT    = 5;
   localparam int GLITCH_MUL_W   = 6;
   localparam logic [5:0] GLITCH_MUL = 6'h29;
   localparam int GLITCH_SHIFT   = 12;
   localparam logic [3:0] PEAK_RST   = 4'h0;
   localparam logic [3:0] DAC_RST    = 4'h0;
   localparam logic [7:0] CFG_ZERO   = 8'h00;
   localparam int MISC_AUTO_BIT  = 7;
   localparam int MISC_DGL_BIT   = 3;
   localparam int STAT_PEAK_LSB  = 4;
   localparam int STAT_CLH_BIT   = 1;
   localparam int STAT_CLL_BIT   = 0;

   typedef enum logic [1:0] {
      VRSPC_OFF   = 2'b00,
      VRSPC_ARMED = 2'b01,
      VRSPC_BLANK = 2'b10
   } vrspc_state_t;
endpackage

// [hdl/vrspc_sync.sv]
module vrspc_sync
   import vrspc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
      end
   end

   assign dout = sync_reg;
endmodule

// [hdl/vrspc_top.sv]
module vrspc_top
   import vrspc_pkg::*;
#(
   parameter int CNT_W    = CNT_W_DEF,
   parameter int LADDER_W = LADDER_W_DEF
) (
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic                serialReset,
   input  wire logic [CFG_W-1:0]    crankCfg,
   input  wire logic [CFG_W-1:0]    runCfg,
   input  wire logic                autoThreshEn,
   input  wire logic                deglitchEn,
   input  wire logic                lowRefSel,
   input  wire logic                vrsDisable,
   input  wire logic                compIn,
   input  wire logic [LADDER_W-1:0] peakLadder,
   input  wire logic                clampHighIn,
   input  wire logic                clampLowIn,
   output logic                     vrsOut,
   output logic [CODE_W-1:0]        dacCode,
   output logic                     circuitEn,
   output logic                     autoThreshMode,
   output logic [CFG_W-1:0]         vrsStatus,
   output logic [CNT_W-1:0]         refPeriod
);
   // ---------------- local reset ----------------
   // the serial reset command returns every register to its default,
   // exactly like the power-on reset
   wire localRst = !nrst || serialReset;
   wire localNrst = !localRst;

   // ---------------- pin synchronisers ----------------
   logic                compSync;
   logic                clampHighSync;
   logic                clampLowSync;
   logic [LADDER_W-1:0] ladderSync;

   vrspc_sync #(
      .WIDTH (1)
   ) u_syncComp (
      .clk  (clk),
      .nrst (localNrst),
      .din  (compIn),
      .dout (compSync)
   );

   // each ladder bit comes from its own comparator; a one-clock skew between
   // bits only delays the maximum by a clock, it cannot corrupt it
   vrspc_sync #(
      .WIDTH (LADDER_W + 2)
   ) u_syncStat (
      .clk  (clk),
      .nrst (localNrst),
      .din  ({clampHighIn, clampLowIn, peakLadder}),
      .dout ({clampHighSync, clampLowSync, ladderSync})
   );

   // ---------------- configuration selection ----------------
   wire                crankActive = (crankCfg != CFG_ZERO);
   wire [CFG_W-1:0]    selCfg = crankActive ? crankCfg : runCfg;
   wire [CODE_W-1:0]   thrCode = selCfg[THR_LSB +: CODE_W];
   wire [CODE_W-1:0]   blankCode = selCfg[BLANK_LSB +: CODE_W];

   // ---------------- registers ----------------
   vrspc_state_t        state_reg;
   vrspc_state_t        state_next;
   logic                vrsOut_reg;
   logic                vrsOut_next;
   logic [CNT_W-1:0]    blankCnt_reg;
   logic [CNT_W-1:0]    blankCnt_next;
   logic [CNT_W-1:0]    pulseCnt_reg;
   logic [CNT_W-1:0]    pulseCnt_next;
   logic [CNT_W-1:0]    refPeriod_reg;
   logic [CNT_W-1:0]    refPeriod_next;
   logic [CODE_W-1:0]   peakRun_reg;
   logic [CODE_W-1:0]   peakRun_next;
   logic [CODE_W-1:0]   peak_reg;
   logic [CODE_W-1:0]   peak_next;
   logic [CODE_W-1:0]   dacCode_reg;
   logic                circuitEn_reg;
   logic                autoThresh_reg;
   logic                clampHigh_reg;
   logic                clampLow_reg;

   // ---------------- derived lengths ----------------
   // blanking = period * code / 32, so code 15 gives 46.875 percent
   wire [CNT_W+CODE_W-1:0] blankProd = refPeriod_reg * blankCode;
   wire [CNT_W-1:0]        blankLen = CNT_W'(blankProd >> BLANK_SHIFT);

   // glitch window = period * 41 / 4096, about one percent; a shift-and-add
   // avoids a divider at the cost of 0.1 percent error
   wire [CNT_W+GLITCH_MUL_W-1:0] glitchProd = refPeriod_reg * GLITCH_MUL;
   wire [CNT_W-1:0]              glitchLen = CNT_W'(glitchProd >> GLITCH_SHIFT);

   // ---------------- deglitch filter ----------------
   logic compFilt;

   vrspc_deglitch #(
      .CNT_W (CNT_W)
   ) u_deglitch (
      .clk   (clk),
      .nrst  (localNrst),
      .en    (deglitchEn),
      .din   (compSync),
      .limit (glitchLen),
      .dout  (compFilt)
   );

   // ---------------- peak code ----------------
   // thermometer ladder to binary: number of levels exceeded, so the code
   // never falls while the input rises
   function automatic logic [CODE_W-1:0] ladderCode(input logic [LADDER_W-1:0] t);
      logic [CODE_W-1:0] n;
      n = '0;
      for (int i = 0; i < LADDER_W; i++) begin
         n = n + CODE_W'(t[i]);
      end
      return n;
   endfunction

   wire [CODE_W-1:0] ladderNow = ladderCode(ladderSync);
   wire [CODE_W-1:0] peakMax = (ladderNow > peakRun_reg) ? ladderNow : peakRun_reg;

   // ---------------- edge acceptance ----------------
   wire enabled = !vrsDisable;
   wire refLevel = !lowRefSel;
   wire edgeSeen = (compFilt != vrsOut_reg);
   wire accept = (state_reg == VRSPC_ARMED) && edgeSeen;
   wire inRefPulse = (vrsOut_reg == refLevel);
   wire endRefPulse = accept && inRefPulse;
   wire startRefPulse = accept && !inRefPulse;
   wire fallEdge = accept && vrsOut_reg;
   wire riseEdge = accept && !vrsOut_reg;
   wire blankDone = (blankCnt_reg + 1'b1 >= blankLen);
   wire pulseSat = (pulseCnt_reg == {CNT_W{1'b1}});

   // ---------------- state machine ----------------
   always_comb begin
      state_next = state_reg;
      vrsOut_next = vrsOut_reg;
      blankCnt_next = blankCnt_reg;
      unique case (state_reg)
         VRSPC_OFF: begin
            vrsOut_next = 1'b0;
            blankCnt_next = '0;
            if (enabled) begin
               state_next = VRSPC_ARMED;
            end
         end
         VRSPC_ARMED: begin
            if (!enabled) begin
               state_next = VRSPC_OFF;
               vrsOut_next = 1'b0;
            end else if (edgeSeen) begin
               vrsOut_next = compFilt;
               blankCnt_next = '0;
               if (blankLen != '0) begin
                  state_next = VRSPC_BLANK;
               end
            end
         end
         VRSPC_BLANK: begin
            // comparator changes are ignored here; the output holds unless vrsDisable forces it low
            blankCnt_next = blankCnt_reg + 1'b1;
            if (!enabled) begin
               state_next = VRSPC_OFF;
               vrsOut_next = 1'b0;
            end else if (blankDone) begin
               state_next = VRSPC_ARMED;
            end
         end
         default: begin
            state_next = VRSPC_OFF;
            vrsOut_next = 1'b0;
            blankCnt_next = '0;
         end
      endcase
   end

   // ---------------- period measurement ----------------
   // the count saturates so a stalled engine shows the longest period
   // rather than wrapping to a short one
   always_comb begin
      pulseCnt_next = pulseCnt_reg;
      refPeriod_next = refPeriod_reg;
      if (!enabled) begin
         pulseCnt_next = '0;
      end else if (startRefPulse) begin
         pulseCnt_next = '0;
      end else if (endRefPulse) begin
         refPeriod_next = pulseSat ? pulseCnt_reg : pulseCnt_reg + 1'b1;
         pulseCnt_next = '0;
      end else if (inRefPulse && !pulseSat) begin
         pulseCnt_next = pulseCnt_reg + 1'b1;
      end
   end

   // ---------------- peak tracking ----------------
   always_comb begin
      peakRun_next = peakRun_reg;
      peak_next = peak_reg;
      if (riseEdge) begin
         peakRun_next = ladderNow;
      end else if (fallEdge) begin
         // zero crossing after the positive half: publish and hold
         peak_next = peakMax;
         peakRun_next = '0;
      end else if (vrsOut_reg) begin
         peakRun_next = peakMax;
      end
   end

   // ---------------- flops ----------------
   always_ff @(posedge clk) begin
      if (localRst) begin
         state_reg <= VRSPC_OFF;
         vrsOut_reg <= 1'b0;
         blankCnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         vrsOut_reg <= vrsOut_next;
         blankCnt_reg <= blankCnt_next;
      end
   end

   always_ff @(posedge clk) begin
      if (localRst) begin
         pulseCnt_reg <= '0;
         refPeriod_reg <= '0;
      end else begin
         pulseCnt_reg <= pulseCnt_next;
         refPeriod_reg <= refPeriod_next;
      end
   end

   // only the two resets clear the published peak
   always_ff @(posedge clk) begin
      if (localRst) begin
         peakRun_reg <= PEAK_RST;
         peak_reg <= PEAK_RST;
      end else begin
         peakRun_reg <= peakRun_next;
         peak_reg <= peak_next;
      end
   end

   always_ff @(posedge clk) begin
      if (localRst) begin
         dacCode_reg <= DAC_RST;
         circuitEn_reg <= 1'b0;
         autoThresh_reg <= 1'b0;
         clampHigh_reg <= 1'b0;
         clampLow_reg <= 1'b0;
      end else begin
         dacCode_reg <= thrCode;
         circuitEn_reg <= enabled;
         autoThresh_reg <= autoThreshEn && enabled;
         clampHigh_reg <= clampHighSync && enabled;
         clampLow_reg <= clampLowSync && enabled;
      end
   end

   // ---------------- outputs ----------------
   assign vrsOut = vrsOut_reg;
   assign dacCode = dacCode_reg;
   assign circuitEn = circuitEn_reg;
   assign autoThreshMode = autoThresh_reg;
   assign refPeriod = refPeriod_reg;
   always_comb begin
      vrsStatus = '0;
      vrsStatus[STAT_PEAK_LSB +: CODE_W] = peak_reg;
      vrsStatus[STAT_CLH_BIT] = clampHigh_reg;
      vrsStatus[STAT_CLL_BIT] = clampLow_reg;
   end
endmodule

// [sim/vrspc_sensor_model.sv]
module vrspc_sensor_model
   import vrspc_pkg::*;
#(
   parameter int LADDER_W = LADDER_W_DEF
) (
   input  wire logic           clk,
   output logic                compIn,
   output logic [LADDER_W-1:0] peakLadder,
   output logic                clampHighIn,
   output logic                clampLowIn
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      compIn = 1'b0;
      peakLadder = '0;
      clampHighIn = 1'b0;
      clampLowIn = 1'b0;
   end
   // one tooth: high then low; caller sits just after an edge, so lengths are exact
   task automatic tooth(input int hi, input int lo, input logic [3:0] pk, input logic [1:0] cl);
      compIn = 1'b1;
      peakLadder = LADDER_W'((16'h1 << pk) - 16'h1);
      {clampHighIn, clampLowIn} = cl;
      repeat (hi) @(posedge clk);
      #1;
      compIn = 1'b0;
      peakLadder = '0;
      repeat (lo) @(posedge clk);
      #1;
   endtask
endmodule

// [sim/vrspc_top_asserts.sv]
module vrspc_top_asserts
   import vrspc_pkg::*;
#(
   parameter int CNT_W = CNT_W_DEF
) (
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              serialReset,
   input wire logic [CFG_W-1:0]  crankCfg,
   input wire logic [CFG_W-1:0]  runCfg,
   input wire logic              autoThreshEn,
   input wire logic              vrsDisable,
   input wire logic              clampHighIn,
   input wire logic              clampLowIn,
   input wire logic              vrsOut,
   input wire logic [CODE_W-1:0] dacCode,
   input wire logic              circuitEn,
   input wire logic              autoThreshMode,
   input wire logic [CFG_W-1:0]  vrsStatus,
   input wire logic [CNT_W-1:0]  refPeriod
);
   timeunit 1ns;
   timeprecision 100ps;
   wire logic [CODE_W-1:0] selThr = (crankCfg != CFG_ZERO) ? crankCfg[7:4] : runCfg[7:4];
   wire logic              live   = nrst && !serialReset;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!live);
   property p_dac_sel;
      $past(live) && $past(live, 2) |-> dacCode == $past(selThr);
   endproperty
   a_dac_sel: assert property (p_dac_sel) else $error("dac code not from selected register");
   property p_circ_en;
      $past(live) && $past(live, 2) |-> circuitEn == !$past(vrsDisable);
   endproperty
   a_circ_en: assert property (p_circ_en) else $error("circuit enable wrong");
   property p_auto;
      $past(live) && $past(live, 2) |-> autoThreshMode == $past(autoThreshEn && !vrsDisable);
   endproperty
   a_auto: assert property (p_auto) else $error("auto mode flag wrong");
   property p_off;
      vrsDisable [*2] |-> !vrsOut;
   endproperty
   a_off: assert property (p_off) else $error("output active while disabled");
   property p_rsv;
      vrsStatus[3:2] == 2'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("unused status bits set");
   // the peak is published on the same edge that drops the output
   property p_peak;
      $past(live) && $changed(vrsStatus[7:4]) |-> $past(vrsOut) && !vrsOut;
   endproperty
   a_peak: assert property (p_peak) else $error("peak code moved outside a pulse end");
   property p_ref;
      $past(live) && $changed(refPeriod) |-> $changed(vrsOut) || $past(vrsOut) != $past(vrsOut, 2);
   endproperty
   a_ref: assert property (p_ref) else $error("period moved without output edge");
   property p_clh;
      (clampHighIn && !vrsDisable) [*5] |-> vrsStatus[STAT_CLH_BIT];
   endproperty
   a_clh: assert property (p_clh) else $error("high clamp flag missing");
   property p_cll;
      !clampLowIn [*5] |-> !vrsStatus[STAT_CLL_BIT];
   endproperty
   a_cll: assert property (p_cll) else $error("low clamp flag without clamp");
endmodule

bind vrspc_top vrspc_top_asserts #(.CNT_W(CNT_W)) i_vrspc_top_asserts (.clk(clk), .nrst(nrst),
   .serialReset(serialReset), .crankCfg(crankCfg), .runCfg(runCfg), .autoThreshEn(autoThreshEn),
   .vrsDisable(vrsDisable), .clampHighIn(clampHighIn), .clampLowIn(clampLowIn), .vrsOut(vrsOut),
   .dacCode(dacCode), .circuitEn(circuitEn), .autoThreshMode(autoThreshMode), .vrsStatus(vrsStatus),
   .refPeriod(refPeriod));

// [sim/vrspc_top_test.sv]
module vrspc_top_test
   import vrspc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {int sel; logic [23:0] val;} vrspc_note_t;
   logic                 clk, nrst, serialReset, autoThreshEn, deglitchEn, lowRefSel, vrsDisable;
   logic [CFG_W-1:0]     crankCfg, runCfg;
   wire logic            compIn, clampHighIn, clampLowIn, vrsOut, circuitEn, autoThreshMode;
   wire logic [14:0]     peakLadder;
   wire logic [3:0]      dacCode;
   wire logic [7:0]      vrsStatus;
   wire logic [23:0]     refPeriod;
   vrspc_note_t          q[$];
   vrspc_note_t          n;
   event                 look;
   int                   fails, checkCount, cycles, i, seed;
   logic [3:0]           pk;
   logic [1:0]           cl;
   logic [3:0]           codes[4] = '{4'h0, 4'h1, 4'h8, 4'hF};
   int                   expl[4] = '{60, 60, 67, 67};

   vrspc_top #(.CNT_W(24), .LADDER_W(15)) i_vrspc_top (.clk(clk), .nrst(nrst), .serialReset(serialReset),
      .crankCfg(crankCfg), .runCfg(runCfg), .autoThreshEn(autoThreshEn), .deglitchEn(deglitchEn),
      .lowRefSel(lowRefSel), .vrsDisable(vrsDisable), .compIn(compIn), .peakLadder(peakLadder),
      .clampHighIn(clampHighIn), .clampLowIn(clampLowIn), .vrsOut(vrsOut), .dacCode(dacCode),
      .circuitEn(circuitEn), .autoThreshMode(autoThreshMode), .vrsStatus(vrsStatus), .refPeriod(refPeriod));
   vrspc_sensor_model #(.LADDER_W(15)) i_vrspc_sensor_model (.clk(clk), .compIn(compIn),
      .peakLadder(peakLadder), .clampHighIn(clampHighIn), .clampLowIn(clampLowIn));

   always #2 clk = ~clk;

   function automatic logic [23:0] pick(input int sel);
      case (sel)
         0: pick = {20'h0, dacCode};
         1: pick = {23'h0, circuitEn};
         2: pick = {23'h0, autoThreshMode};
         3: pick = refPeriod;
         5: pick = {23'h0, vrsOut};
         default: pick = {16'h0, vrsStatus};
      endcase
   endfunction

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checkCount++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // one note per cycle so no trigger of look is lost
   task automatic note(input int sel, input logic [23:0] val);
      q.push_back('{sel, val});
      -> look;
      cyc(1);
   endtask

   task automatic done(input string name);
      $display("test %0s done", name);
   endtask

   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial forever begin
      @(look);
      n = q.pop_front();
      check(pick(n.sel), n.val);
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      serialReset = 1'b0;
      {autoThreshEn, deglitchEn, lowRefSel, vrsDisable} = 4'h0;
      crankCfg = CFG_ZERO;
      runCfg = CFG_ZERO;
      seed = 9559;
      cyc(8);
      nrst = 1'b1;
      cyc(3);
      note(1, 24'h1);
      note(4, 24'h0);
      note(3, 24'h0);
      done("reset");
      for (i = 0; i < 24; i++) begin
         crankCfg = (i % 3 == 0) ? CFG_ZERO : 8'($random(seed));
         runCfg = 8'($random(seed));
         {autoThreshEn, vrsDisable, deglitchEn} = 3'($random(seed));
         cyc(2);
         note(0, {20'h0, (crankCfg != CFG_ZERO) ? crankCfg[7:4] : runCfg[7:4]});
         note(1, {23'h0, !vrsDisable});
         note(2, {23'h0, autoThreshEn && !vrsDisable});
      end
      crankCfg = CFG_ZERO;
      runCfg = CFG_ZERO;
      {autoThreshEn, vrsDisable, deglitchEn} = 3'h0;
      cyc(2);
      done("config");
      for (i = 0; i < 4; i++) begin
         pk = 4'($random(seed));
         cl = 2'($random(seed));
         i_vrspc_sensor_model.tooth(20 + 7 * i, 30, pk, cl);
         note(3, 24'(20 + 7 * i));
         note(4, {16'h0, pk, 2'h0, cl});
      end
      done("peak");
      lowRefSel = 1'b1;
      i_vrspc_sensor_model.tooth(20, 37, 4'h3, 2'h0);
      i_vrspc_sensor_model.tooth(20, 30, 4'h3, 2'h0);
      note(3, 24'd37);
      lowRefSel = 1'b0;
      done("lowref");
      // a 2-cycle dip after 5 high cycles is swallowed only when blanking covers it
      for (i = 0; i < 4; i++) begin
         runCfg = {4'h5, codes[i]};
         i_vrspc_sensor_model.tooth(64, 64, 4'h1, 2'h0);
         i_vrspc_sensor_model.tooth(5, 2, 4'h1, 2'h0);
         i_vrspc_sensor_model.tooth(60, 40, 4'h1, 2'h0);
         note(3, 24'(expl[i]));
      end
      runCfg = CFG_ZERO;
      done("blank");
      deglitchEn = 1'b1;
      i_vrspc_sensor_model.tooth(200, 200, 4'h1, 2'h0);
      i_vrspc_sensor_model.tooth(50, 2, 4'h1, 2'h0);
      i_vrspc_sensor_model.tooth(50, 60, 4'h1, 2'h0);
      note(3, 24'd102);
      deglitchEn = 1'b0;
      done("deglitch");
      vrsDisable = 1'b1;
      i_vrspc_sensor_model.tooth(20, 20, 4'hF, 2'h0);
      vrsDisable = 1'b0;
      cyc(3);
      note(4, 24'h10);
      note(3, 24'd102);
      // output follows the pin four clocks late: still high three clocks after the pin falls
      i_vrspc_sensor_model.tooth(10, 0, 4'h2, 2'h0);
      note(5, 24'h1);
      cyc(2);
      note(5, 24'h1);
      note(5, 24'h0);
      serialReset = 1'b1;
      cyc(1);
      serialReset = 1'b0;
      cyc(2);
      note(4, 24'h0);
      done("hold");
      report_and_stop();
   end
endmodule
